// >>> common/pmc_pkg.sv
// Behaviour
// (RULE1) control bit 15 self-clearing full device reset; the code reloads only the control register
// (RULE2) control bit 14 enables loopback, default 0
// (RULE3) bit 13 speed 100 default; bit 8 duplex
// (RULE4) control bit 12 enables autonegotiation, default 1
// (RULE5) control bit 11 powerdown, default 0, readable
// (RULE6) bit 10 port off; default from straps all-ones
// (RULE7) bit 9 restarts autonegotiation, clears when done
// (RULE8) control bit 7 enables collision test
// (RULE9) status 15..11 fixed ability bits, T4 zero
// (RULE10) status bit 6 zero: preamble always needed
// (RULE11) status bit 5 shows acknowledge complete
// (RULE12) status bit 4 latches interrupt or remote fault
// (RULE13) status bit 2 link, latches low on loss
// (RULE14) status bit 1 jabber, latches high until read
// (RULE15) status bits 3 and 0 always one
// (RULE16) register data shifted bit 15 first
// (RULE17) latched bits release only after status read
package pmc_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [4:0]  PMC_REG_CONTROL   = 5'h00;
	localparam logic [4:0]  PMC_REG_STATUS    = 5'h01;
	localparam logic [15:0] PMC_CTRL_DEFAULT  = 16'h3400;
	localparam logic [4:0]  PMC_STRAPS_ALL_ON = 5'h1F;
	localparam logic [15:0] PMC_STATUS_CONST  = 16'h7809;
	localparam int          PMC_ST_ACK_BIT    = 5;
	localparam int          PMC_ST_FAULT_BIT  = 4;
	localparam int          PMC_ST_LINK_BIT   = 2;
	localparam int          PMC_ST_JAB_BIT    = 1;

	// ----------------------------------------------------------------
	// management frame
	// ----------------------------------------------------------------
	localparam logic [5:0]  PMC_PREAMBLE_BITS = 6'h20;
	localparam logic [5:0]  PMC_HDR_BITS      = 6'h0D;
	localparam logic [5:0]  PMC_DATA_BITS     = 6'h10;
	localparam logic [1:0]  PMC_OP_READ       = 2'h2;
	localparam logic [1:0]  PMC_OP_WRITE      = 2'h1;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int          PMC_CLK_MHZ        = 125;
	localparam int          PMC_SOFT_RESET_NS  = 2000;
	localparam logic [9:0]  PMC_SOFT_RESET_CYC =
		10'((PMC_SOFT_RESET_NS * PMC_CLK_MHZ + 999) / 1000);

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       reset;
		logic       loopback_enable;
		logic       speed_100;
		logic       autoneg_enable;
		logic       power_down;
		logic       controller_port_off;
		logic       autoneg_restart;
		logic       full_duplex_select;
		logic       collision_test_enable;
		logic [6:0] spare;
	} pmc_ctrl_t;

	typedef struct packed {
		logic link_fail;
		logic jabber;
		logic interrupt_detect;
		logic partner_remote_fault;
		logic autoneg_ack_done;
	} pmc_live_t;

	typedef enum logic [3:0] {
		PMC_S_PRE  = 4'h1,
		PMC_S_HDR  = 4'h2,
		PMC_S_TA   = 4'h4,
		PMC_S_DATA = 4'h8
	} pmc_frame_state_t;

endpackage

// >>> rtl/pmc_mgmt_serial.sv
`timescale 1ns/1ns
module pmc_mgmt_serial
	import pmc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        bit_tick,
	input  wire logic        serial_in,
	input  wire logic [4:0]  phy_addr,
	input  wire logic [15:0] rd_data,
	output logic      [4:0]  reg_addr,
	output logic      [15:0] wr_data,
	output logic             wr_stb,
	output logic             rd_take,
	output logic             serial_out,
	output logic             serial_oe
);

	pmc_frame_state_t state_r;
	logic [5:0]       cnt_r;
	logic [15:0]      shift_r;
	logic             is_read_r;
	logic [12:0]      hdr_w;

	// start bit, opcode, phy address, register address
	assign hdr_w = {shift_r[11:0], serial_in};

	// ----------------------------------------------------------------
	// frame walker, one step per rising management clock
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_r    <= PMC_S_PRE;
			cnt_r      <= 6'h00;
			shift_r    <= 16'h0000;
			is_read_r  <= 1'b0;
			reg_addr   <= 5'h00;
			wr_data    <= 16'h0000;
			wr_stb     <= 1'b0;
			rd_take    <= 1'b0;
			serial_out <= 1'b0;
			serial_oe  <= 1'b0;
		end
		else
		begin
			wr_stb  <= 1'b0;
			rd_take <= 1'b0;
			if (bit_tick)
			begin
				unique case (state_r)
					PMC_S_PRE:
					begin
						// no suppressed preamble: a full run of ones each frame
						if (serial_in)
						begin
							if (cnt_r != PMC_PREAMBLE_BITS)
								cnt_r <= cnt_r + 6'h01; // see RULE10
						end
						else if (cnt_r == PMC_PREAMBLE_BITS)
						begin
							state_r <= PMC_S_HDR;
							cnt_r   <= 6'h00;
						end
						else
							cnt_r <= 6'h00;
					end
					PMC_S_HDR:
					begin
						shift_r <= {shift_r[14:0], serial_in};
						cnt_r   <= cnt_r + 6'h01;
						if (cnt_r == PMC_HDR_BITS - 6'h01)
						begin
							cnt_r <= 6'h00;
							if (hdr_w[12] && hdr_w[9:5] == phy_addr &&
								(hdr_w[11:10] == PMC_OP_READ || hdr_w[11:10] == PMC_OP_WRITE))
							begin
								state_r   <= PMC_S_TA;
								is_read_r <= (hdr_w[11:10] == PMC_OP_READ);
								reg_addr  <= hdr_w[4:0];
							end
							else
								state_r <= PMC_S_PRE;
						end
					end
					PMC_S_TA:
					begin
						cnt_r <= cnt_r + 6'h01;
						if (cnt_r == 6'h00)
						begin
							if (is_read_r)
							begin
								serial_oe  <= 1'b1;
								serial_out <= 1'b0;
								rd_take    <= 1'b1;
								shift_r    <= rd_data;
							end
						end
						else
						begin
							state_r <= PMC_S_DATA;
							cnt_r   <= 6'h00;
							if (is_read_r)
							begin
								serial_out <= shift_r[15]; // see RULE16
								shift_r    <= {shift_r[14:0], 1'b0};
							end
						end
					end
					PMC_S_DATA:
					begin
						cnt_r <= cnt_r + 6'h01;
						if (is_read_r)
						begin
							if (cnt_r == PMC_DATA_BITS - 6'h01)
							begin
								serial_oe  <= 1'b0;
								serial_out <= 1'b0;
								state_r    <= PMC_S_PRE;
								cnt_r      <= 6'h00;
							end
							else
							begin
								serial_out <= shift_r[15]; // see RULE16
								shift_r    <= {shift_r[14:0], 1'b0};
							end
						end
						else
						begin
							shift_r <= {shift_r[14:0], serial_in}; // see RULE16
							if (cnt_r == PMC_DATA_BITS - 6'h01)
							begin
								wr_data <= {shift_r[14:0], serial_in};
								wr_stb  <= 1'b1;
								state_r <= PMC_S_PRE;
								cnt_r   <= 6'h00;
							end
						end
					end
					default:
					begin
						state_r <= PMC_S_PRE;
						cnt_r   <= 6'h00;
					end
				endcase
			end
		end
	end

endmodule // pmc_mgmt_serial

// >>> rtl/pmc_regs.sv
`timescale 1ns/1ns
module pmc_regs
	import pmc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       mdc,
	input  wire logic       mdio_i,
	output logic            mdio_o,
	output logic            mdio_oe,
	input  wire logic [4:0] mgmt_addr_straps,
	input  wire pmc_live_t  live,
	input  wire logic       autoneg_restart_done,
	output pmc_ctrl_t       ctrl_o
);

	localparam int RST_MAX = 300;

	logic [6:0]  sync1_r;
	logic [6:0]  sync2_r;
	logic        mdc_d_r;
	logic        mdc_rise;
	logic [4:0]  straps_s;
	logic [1:0]  strap_cnt_r;
	logic        strap_load;
	pmc_ctrl_t   ctrl_r;
	logic [9:0]  rst_cnt_r;
	logic        fault_r;
	logic        jab_r;
	logic        link_r;
	logic        fault_d_r;
	logic        jab_d_r;
	logic        link_d_r;
	logic        fault_live;
	logic        link_live;
	logic [4:0]  reg_addr;
	logic [15:0] wr_data;
	logic        wr_stb;
	logic        rd_take;
	logic        ctrl_wr;
	logic        stat_rd;
	logic [15:0] status_word;
	logic [15:0] rd_data;

	function automatic pmc_ctrl_t pmc_defaults(input logic [4:0] straps);
		pmc_ctrl_t d;
		d = pmc_ctrl_t'(PMC_CTRL_DEFAULT);
		d.controller_port_off = (straps == PMC_STRAPS_ALL_ON);
		return d;
	endfunction

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			sync1_r <= 7'h00;
			sync2_r <= 7'h00;
			mdc_d_r <= 1'b0;
		end
		else
		begin
			sync1_r <= {mgmt_addr_straps, mdio_i, mdc};
			sync2_r <= sync1_r;
			mdc_d_r <= sync2_r[0];
		end
	end

	assign mdc_rise = sync2_r[0] & ~mdc_d_r;
	assign straps_s = sync2_r[6:2];

	// straps are sampled only once the synchroniser has filled
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			strap_cnt_r <= 2'h0;
		else if (strap_cnt_r != 2'h3)
			strap_cnt_r <= strap_cnt_r + 2'h1;
	end

	assign strap_load = (strap_cnt_r == 2'h2);

	// ----------------------------------------------------------------
	// serial frame engine
	// ----------------------------------------------------------------
	pmc_mgmt_serial u_serial (
		.clk        (clk),
		.resetn     (resetn),
		.bit_tick   (mdc_rise),
		.serial_in  (sync2_r[1]),
		.phy_addr   (straps_s),
		.rd_data    (rd_data),
		.reg_addr   (reg_addr),
		.wr_data    (wr_data),
		.wr_stb     (wr_stb),
		.rd_take    (rd_take),
		.serial_out (mdio_o),
		.serial_oe  (mdio_oe)
	);

	// writes are dropped while the soft reset runs
	assign ctrl_wr = wr_stb && reg_addr == PMC_REG_CONTROL && !ctrl_r.reset;
	assign stat_rd = rd_take && reg_addr == PMC_REG_STATUS;

	// ----------------------------------------------------------------
	// control register
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ctrl_r    <= pmc_ctrl_t'(PMC_CTRL_DEFAULT);
			rst_cnt_r <= 10'h000;
		end
		else
		begin
			if (strap_load)
				ctrl_r.controller_port_off <= (straps_s == PMC_STRAPS_ALL_ON); // see RULE6
			if (autoneg_restart_done)
				ctrl_r.autoneg_restart <= 1'b0; // see RULE7
			if (ctrl_r.reset)
			begin
				rst_cnt_r <= rst_cnt_r - 10'h001;
				if (rst_cnt_r == 10'h001)
					ctrl_r <= pmc_defaults(straps_s); // see RULE1
			end
			if (ctrl_wr)
			begin
				// see RULE2, see RULE3, see RULE4, see RULE5, see RULE8
				ctrl_r <= pmc_ctrl_t'(wr_data);
				// writing zero must not abort a restart in flight
				ctrl_r.autoneg_restart <= wr_data[9] |
					(ctrl_r.autoneg_restart & ~autoneg_restart_done); // see RULE7
				if (wr_data[15])
					rst_cnt_r <= PMC_SOFT_RESET_CYC; // see RULE1
			end
		end
	end

	assign ctrl_o = ctrl_r;

	// ----------------------------------------------------------------
	// latched status, a new event beats the read release
	// ----------------------------------------------------------------
	assign fault_live = live.interrupt_detect | live.partner_remote_fault;
	assign link_live  = ~live.link_fail;

	// a read reports the flags as they stood before its capture edge;
	// only what was reported may be released, or an event is lost unseen
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			fault_d_r <= 1'b0;
			jab_d_r   <= 1'b0;
			link_d_r  <= 1'b0;
		end
		else
		begin
			fault_d_r <= fault_r;
			jab_d_r   <= jab_r;
			link_d_r  <= link_r;
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			fault_r <= 1'b0;
			jab_r   <= 1'b0;
			link_r  <= 1'b0;
		end
		else
		begin
			fault_r <= fault_live | (fault_r & ~(stat_rd & fault_d_r)); // see RULE12, see RULE17
			jab_r   <= live.jabber | (jab_r & ~(stat_rd & jab_d_r)); // see RULE14, see RULE17
			link_r  <= link_live & (link_r | (stat_rd & ~link_d_r)); // see RULE13, see RULE17
		end
	end

	// ----------------------------------------------------------------
	// read mux, unmapped addresses read zero
	// ----------------------------------------------------------------
	always_comb
	begin
		status_word = PMC_STATUS_CONST; // see RULE9, see RULE10, see RULE15
		status_word[PMC_ST_ACK_BIT]   = live.autoneg_ack_done; // see RULE11
		status_word[PMC_ST_FAULT_BIT] = fault_r;
		status_word[PMC_ST_LINK_BIT]  = link_r;
		status_word[PMC_ST_JAB_BIT]   = jab_r;
		unique case (reg_addr)
			PMC_REG_CONTROL: rd_data = ctrl_r;
			PMC_REG_STATUS:  rd_data = status_word;
			default:         rd_data = 16'h0000;
		endcase
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence s_reset_write;
		ctrl_wr && wr_data[15];
	endsequence

	sequence s_reset_running;
		ctrl_r.reset [*3];
	endsequence

	a_soft_reset_ends: assert property ( // see RULE1
		s_reset_write |=> s_reset_running ##[1:RST_MAX] !ctrl_r.reset)
		else $error("soft reset bit did not self clear in time");

	a_loopback_write: assert property ( // see RULE2
		ctrl_wr |=> ctrl_r.loopback_enable == $past(wr_data[14]))
		else $error("loopback bit not taken from write");

	a_speed_duplex: assert property ( // see RULE3
		ctrl_wr |=> ctrl_r.speed_100 == $past(wr_data[13]) &&
			ctrl_r.full_duplex_select == $past(wr_data[8]))
		else $error("speed or duplex bit not taken from write");

	a_strap_default: assert property ( // see RULE6
		strap_load |=> ctrl_r.controller_port_off == (straps_s == PMC_STRAPS_ALL_ON))
		else $error("port off default does not follow straps");

	a_restart_clears: assert property ( // see RULE7
		ctrl_r.autoneg_restart && autoneg_restart_done && !ctrl_wr |=> !ctrl_r.autoneg_restart)
		else $error("restart bit did not clear on completion");

	a_fixed_bits: assert property ( // see RULE9
		reg_addr == PMC_REG_STATUS |-> (rd_data & 16'hFFC9) == PMC_STATUS_CONST)
		else $error("fixed status bits wrong");

	a_fault_latch: assert property ( // see RULE12
		fault_live ##1 !stat_rd [*2] |-> fault_r)
		else $error("remote fault not latched");

	a_link_low: assert property ( // see RULE13
		!link_live ##1 !stat_rd |-> !link_r)
		else $error("link bit not latched low");

	a_jabber_release: assert property ( // see RULE14
		stat_rd && jab_d_r && !live.jabber |=> !jab_r)
		else $error("jabber not released after read");

	a_link_hold: assert property ( // see RULE17
		!link_r && !stat_rd |=> !link_r)
		else $error("link rose without a status read");

	a_autoneg_write: assert property ( // see RULE4
		ctrl_wr |=> ctrl_r.autoneg_enable == $past(wr_data[12]))
		else $error("autonegotiation enable not taken from write");

	a_powerdown_write: assert property ( // see RULE5
		ctrl_wr |=> ctrl_r.power_down == $past(wr_data[11]))
		else $error("powerdown bit not taken from write");

	a_coltest_write: assert property ( // see RULE8
		ctrl_wr |=> ctrl_r.collision_test_enable == $past(wr_data[7]))
		else $error("collision test bit not taken from write");

	a_restart_set: assert property ( // see RULE7
		ctrl_wr && wr_data[9] |=> ctrl_r.autoneg_restart)
		else $error("restart bit not set by write");

	a_reset_busy: assert property ( // see RULE1
		rst_cnt_r != 10'h000 |-> ctrl_r.reset)
		else $error("reset bit low while soft reset runs");

	a_reset_defaults: assert property ( // see RULE1
		ctrl_r.reset && rst_cnt_r == 10'h001 |=>
			(ctrl_r & 16'hFBFF) == (PMC_CTRL_DEFAULT & 16'hFBFF) &&
			ctrl_r.controller_port_off == ($past(straps_s) == PMC_STRAPS_ALL_ON))
		else $error("control bits not back to defaults after soft reset");

	a_ack_mirror: assert property ( // see RULE11
		reg_addr == PMC_REG_STATUS |-> rd_data[PMC_ST_ACK_BIT] == live.autoneg_ack_done)
		else $error("acknowledge bit does not follow its source");

	a_jabber_latch: assert property ( // see RULE14
		live.jabber |=> jab_r)
		else $error("jabber not latched");

	a_fault_release: assert property ( // see RULE17
		stat_rd && fault_d_r && !fault_live |=> !fault_r)
		else $error("remote fault not released after read");

	a_unread_kept: assert property ( // see RULE17
		stat_rd && !fault_d_r && fault_r |=> fault_r)
		else $error("unreported fault released by read");

	a_jabber_kept: assert property ( // see RULE17
		stat_rd && !jab_d_r && jab_r |=> jab_r)
		else $error("unreported jabber released by read");

	a_link_release: assert property ( // see RULE13
		stat_rd && !link_d_r && link_live |=> link_r)
		else $error("link not restored after read");

endmodule // pmc_regs

// >>> tb/pmc_host_model.sv
`timescale 1ns/1ns
module pmc_host_model
	import pmc_pkg::*;
(
	input  wire logic clk,
	input  wire logic mdio_line,
	output logic      mdc,
	output logic      host_o,
	output logic      host_oe
);
	// clk cycles of mdc high per bit, mdc low lasts one cycle more; raise it for a slow host
	int half = 4;

	initial
	begin
		mdc = 1'b0;
		host_o = 1'b1;
		host_oe = 1'b0;
	end

	// ----------------------------------------
	// one bit slot: data moves while mdc is low, sampled just before the rise
	// ----------------------------------------
	task automatic slot(input logic drv, input logic v, output logic s);
		@(posedge clk);
		host_oe <= drv;
		host_o <= drv ? v : 1'b1;
		repeat (half) @(posedge clk);
		s = mdio_line;
		mdc <= 1'b1;
		repeat (half) @(posedge clk);
		mdc <= 1'b0;
	endtask

	task automatic frame(input int pre, input logic [4:0] phy, input logic [1:0] op,
		input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
		logic [31:0] hdr;
		logic        s;
		logic        w;
		w = (op == PMC_OP_WRITE);
		hdr = {2'b01, op, phy, ra, 2'b10, wd};
		for (int i = 0; i < pre; i++)
			slot(1'b1, 1'b1, s);
		for (int i = 31; i >= 0; i--)
		begin
			slot(w || i > 17, hdr[i], s);
			if (i < 16)
				rd[i] = s;
		end
		// mdc stands still low between frames
		@(posedge clk);
		host_oe <= 1'b0;
	endtask
endmodule // pmc_host_model

// >>> tb/phy_mgmt_control_status_regs_tb_top.sv
`timescale 1ns/1ns
module phy_mgmt_control_status_regs_tb_top
	import pmc_pkg::*;
();
	logic        clk;
	logic        resetn;
	logic        mdc;
	logic        host_o;
	logic        host_oe;
	logic        mdio_o;
	logic        mdio_oe;
	logic        mdio_line;
	logic        an_done;
	logic [4:0]  straps;
	pmc_live_t   live;
	pmc_ctrl_t   ctrl_o;
	logic [15:0] exp_q[$];
	string       name_q[$];
	logic [15:0] got_v;
	logic [15:0] rd;
	logic [15:0] v;
	event        got_ev;
	int          error_cnt;
	int          cmp_count;
	int          seed;

	// pulled-up line: idle or released reads one
	assign mdio_line = mdio_oe ? mdio_o : (host_oe ? host_o : 1'b1);

	pmc_regs u_dut (.clk(clk), .resetn(resetn), .mdc(mdc), .mdio_i(mdio_line),
		.mdio_o(mdio_o), .mdio_oe(mdio_oe), .mgmt_addr_straps(straps), .live(live),
		.autoneg_restart_done(an_done), .ctrl_o(ctrl_o));

	pmc_host_model u_host (.clk(clk), .mdio_line(mdio_line), .mdc(mdc),
		.host_o(host_o), .host_oe(host_oe));

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ----------------------------------------
	// scoreboard
	// ----------------------------------------
	initial
	forever
	begin
		@(got_ev);
		cmp_count++;
		if (got_v !== exp_q[0])
		begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", name_q[0], exp_q[0], got_v);
		end
		void'(exp_q.pop_front());
		void'(name_q.pop_front());
	end

	task automatic note(input string n, input logic [15:0] e);
		name_q.push_back(n);
		exp_q.push_back(e);
	endtask

	task automatic post(input logic [15:0] g);
		got_v = g;
		-> got_ev;
		#1;
	endtask

	task automatic chk_ctrl(input logic [15:0] e);
		note("ctrl_o", e);
		post(ctrl_o);
	endtask

	task automatic wr(input logic [4:0] ra, input logic [15:0] d);
		u_host.frame(32, straps, PMC_OP_WRITE, ra, d, rd);
		repeat (6) @(posedge clk);
	endtask

	task automatic rd_chk(input string n, input logic [4:0] ra, input logic [15:0] e);
		note(n, e);
		u_host.frame(32, straps, PMC_OP_READ, ra, 16'h0000, rd);
		post(rd);
	endtask

	task automatic pulse_live(input pmc_live_t p);
		@(posedge clk);
		live <= live | p;
		@(posedge clk);
		live <= live & ~p;
	endtask

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial
	begin
		repeat (40000) @(posedge clk);
		error_cnt++;
		give_verdict();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		resetn = 1'b0;
		straps = 5'h1F;
		live = '0;
		an_done = 1'b0;
		seed = 32'hB8B35229;
		error_cnt = 0;
		cmp_count = 0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		repeat (6) @(posedge clk);
		chk_ctrl(PMC_CTRL_DEFAULT);
		rd_chk("control", PMC_REG_CONTROL, 16'h3400);
		rd_chk("status", PMC_REG_STATUS, 16'h7809);
		rd_chk("status", PMC_REG_STATUS, 16'h780D);
		$display("defaults test done");
		@(posedge clk);
		live.autoneg_ack_done <= 1'b1;
		pulse_live(5'b01100);
		rd_chk("status", PMC_REG_STATUS, 16'h783F);
		rd_chk("status", PMC_REG_STATUS, 16'h782D);
		pulse_live(5'b10010);
		rd_chk("status", PMC_REG_STATUS, 16'h7839);
		rd_chk("status", PMC_REG_STATUS, 16'h782D);
		$display("latched status test done");
		// random control values, self-clearing bits kept out
		for (int i = 0; i < 4; i++)
		begin
			u_host.half = (i == 1) ? 9 : 4;
			v = 16'($random(seed)) & 16'h7DFF;
			wr(PMC_REG_CONTROL, v);
			chk_ctrl(v);
			rd_chk("control", PMC_REG_CONTROL, v);
		end
		u_host.half = 4;
		$display("control write test done");
		wr(PMC_REG_CONTROL, 16'h1200);
		rd_chk("control", PMC_REG_CONTROL, 16'h1200);
		@(posedge clk);
		an_done <= 1'b1;
		@(posedge clk);
		an_done <= 1'b0;
		rd_chk("control", PMC_REG_CONTROL, 16'h1000);
		$display("restart test done");
		u_host.frame(31, straps, PMC_OP_WRITE, PMC_REG_CONTROL, 16'h0000, rd);
		u_host.frame(32, ~straps, PMC_OP_WRITE, PMC_REG_CONTROL, 16'h0000, rd);
		u_host.frame(32, straps, 2'b11, PMC_REG_CONTROL, 16'h0000, rd);
		rd_chk("control", PMC_REG_CONTROL, 16'h1000);
		wr(5'h02, 16'hA5A5);
		rd_chk("unmapped", 5'h02, 16'h0000);
		$display("refusal test done");
		wr(PMC_REG_CONTROL, 16'hC100);
		note("reset_bit", 16'h0001);
		post({15'h0000, ctrl_o.reset});
		repeat (int'(PMC_SOFT_RESET_CYC) + 10) @(posedge clk);
		chk_ctrl(PMC_CTRL_DEFAULT);
		rd_chk("control", PMC_REG_CONTROL, 16'h3400);
		$display("soft reset test done");
		@(posedge clk);
		straps <= 5'h05;
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		repeat (6) @(posedge clk);
		chk_ctrl(16'h3000);
		rd_chk("control", PMC_REG_CONTROL, 16'h3000);
		$display("strap default test done");
		give_verdict();
	end
endmodule // phy_mgmt_control_status_regs_tb_top
